/* File: logic/dual_wiper_nv_control.sv */
// Dual wiper position control with nonvolatile setting stores behind a two-wire serial slave
// Assumes pins are asynchronous to i_sys_clk; register port is a one-cycle strobe master
//
// Notes on behaviour
// (R1) Direct write loads the addressed wiper register with the received data byte.
// (R2) Restore overwrites wiper register with its saved nonvolatile setting.
// (R3) Save copies the present wiper register into its nonvolatile store.
// (R4) After reset every store is copied to its wiper within under 1 ms.
// (R5) A falling external preset strobe forces the same store-to-wiper copy.
// (R6) Increment and decrement move the addressed wiper one step.
// (R7) Shift left doubles, shift right halves the addressed wiper value.
// (R8) Two independent channels, 6-bit or 8-bit position registers.
// (R9) A store finishes within 25 ms; master waits before relying on it.
// (R10) Ready is low for commands 8, 9, 10, 2, 3, for 1/0.1/20 ms, and for 0.1 ms after reset or a preset strobe.
// (R11) Frame is address, ack, instruction, ack, data with ack, stop.
// (R12) Master can read back each wiper register.
// (R13) A read-only tolerance value can be read by the master.
// (R14) Write protection blocks changes to the nonvolatile stores.
// (R15) Write-protect input is active low; low refuses nonvolatile writes.
// (R16) While a timed update runs, change requests are ignored; a falling preset strobe still copies the stores.
// (R17) Bus address is 01011 followed by the two address-select pins.
// (R18) Nonvolatile stores start at mid-scale.
// (R19) Increment, decrement and shifts saturate at zero and full scale.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dual_wiper_nv_control #(
   parameter int SAVE_CYC    = dual_wiper_pkg::SAVE_CYC_DEF,
   parameter int PRESET_CYC  = dual_wiper_pkg::PRESET_CYC_DEF,
   parameter int RESTORE_CYC = dual_wiper_pkg::RESTORE_CYC_DEF
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output wire logic        o_sda_out,
   output wire logic        o_sda_oe,
   input  wire logic        i_wp_n,
   input  wire logic        i_preset_n,
   input  wire logic        i_address_select_bit_lo,
   input  wire logic        i_address_select_bit_hi,
   output wire logic        o_ready,
   output wire logic [7:0]  o_wiper0,
   output wire logic [7:0]  o_wiper1,
   output wire logic        o_irq,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_we,
   input  wire logic        i_reg_re,
   output wire logic [31:0] o_reg_rdata
);
   import dual_wiper_pkg::*;

   serial_cmd_if bus ();

   logic [5:0]        s1_r;
   logic [5:0]        s2_r;
   logic [5:0]        s3_r;
   logic [5:0]        filt_r;
   logic [5:0]        raw;
   logic              pre_d_r;
   logic              pwrup_r;
   logic [7:0]        wip_r [2];
   logic [7:0]        nv_r [2];
   cmd_t              ins_cmd_r;
   logic              ins_ch_r;
   logic              tol_sel_r;
   logic [BUSY_W-1:0] busy_r;
   logic [EV_W-1:0]   stat_r;
   logic [EV_W-1:0]   en_r;
   logic [31:0]       rdata_r;
   cmd_t              cmd;
   logic              chs;
   logic              ins_stb;
   logic              dat_stb;
   logic              busy;
   logic              accept;
   logic              lock_ev;
   logic              save_req;
   logic              wp_ev;
   logic              save_go;
   logic              ext_preset;
   logic              preset_go;
   logic              restore_go;
   logic              wr_go;
   logic              done_ev;
   logic [EV_W-1:0]   clr;

   serial_byte_engine u_engine (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .bus       (bus.engine)
   );

   // Pin synchronisers: a change counts once stages two and three agree
   assign raw = {i_address_select_bit_hi, i_address_select_bit_lo, i_preset_n, i_wp_n, i_sda, i_scl};
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s1_r   <= SYNC_RST;
         s2_r   <= SYNC_RST;
         s3_r   <= SYNC_RST;
         filt_r <= SYNC_RST;
      end else begin
         s1_r   <= raw;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
      end
   end

   assign bus.scl      = filt_r[0];
   assign bus.sda      = filt_r[1];
   assign bus.dev_addr = {ADDR_FIXED, filt_r[5], filt_r[4]}; // [R17]
   assign o_sda_out    = 1'b0;
   assign o_sda_oe     = bus.sda_oe;

   // Command decode
   assign cmd        = cmd_t'(bus.rx_byte[7:4]);
   assign chs        = bus.rx_byte[0];
   assign ins_stb    = bus.rx_stb & (bus.rx_idx == 2'h1);
   assign dat_stb    = bus.rx_stb & (bus.rx_idx == 2'h2);
   assign busy       = |busy_r;
   assign accept     = ins_stb & ~busy;
   assign lock_ev    = (ins_stb | dat_stb) & busy; // [R16]
   assign save_req   = accept & (cmd == CMD_SAVE_CH || cmd == CMD_SAVE_ALL);
   assign wp_ev      = save_req & ~filt_r[2]; // [R15]
   assign save_go    = save_req & filt_r[2]; // [R14]
   assign ext_preset = pre_d_r & ~filt_r[3]; // [R5]
   assign preset_go  = pwrup_r | ext_preset | (accept & cmd == CMD_PRESET);
   assign restore_go = accept & (cmd == CMD_RESTORE_CH || cmd == CMD_RESTORE_ALL);
   assign wr_go      = dat_stb & ~busy & (ins_cmd_r == CMD_DIRECT);
   assign done_ev    = (busy_r == BUSY_W'(1));

   // Next position for step and shift commands, saturating
   function automatic logic [7:0] step_pos(input cmd_t c, input logic [7:0] w);
      logic [7:0] r;
      r = w;
      case (c)
         CMD_INC: r = (w >= FULL_SCALE) ? FULL_SCALE : w + 8'h01; // [R6] [R19]
         CMD_DEC: r = (w == 8'h00) ? 8'h00 : w - 8'h01; // [R6] [R19]
         CMD_SHL: r = (w > (FULL_SCALE >> 1)) ? FULL_SCALE : {w[6:0], 1'b0}; // [R7] [R19]
         CMD_SHR: r = {1'b0, w[7:1]}; // [R7]
         default: r = w;
      endcase
      return r;
   endfunction : step_pos

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pwrup_r <= 1'b1;
         pre_d_r <= 1'b1;
      end else begin
         pwrup_r <= 1'b0;
         pre_d_r <= filt_r[3];
      end
   end

   // Instruction pointer for data bytes and read-back
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ins_cmd_r <= CMD_NONE;
         ins_ch_r  <= 1'b0;
         tol_sel_r <= 1'b0;
      end else if (accept) begin
         ins_cmd_r <= cmd;
         ins_ch_r  <= chs;
         tol_sel_r <= (cmd == CMD_TOL);
      end else if (ins_stb) begin
         ins_cmd_r <= CMD_NONE; // [R16]
      end
   end

   // Wiper position registers, two channels [R8]
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int c = 0; c < 2; c++) begin
            wip_r[c] <= MID_SCALE;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (preset_go || (restore_go && (cmd == CMD_RESTORE_ALL || chs == 1'(c)))) begin
               wip_r[c] <= nv_r[c]; // [R2] [R4] [R5]
            end else if (wr_go && ins_ch_r == 1'(c)) begin
               wip_r[c] <= bus.rx_byte & FULL_SCALE; // [R1]
            end else if (accept && chs == 1'(c)) begin
               wip_r[c] <= step_pos(cmd, wip_r[c]);
            end
         end
      end
   end

   // Nonvolatile setting stores, mid-scale from delivery
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int c = 0; c < 2; c++) begin
            nv_r[c] <= MID_SCALE; // [R18]
         end
      end else if (save_go) begin
         for (int c = 0; c < 2; c++) begin
            if (cmd == CMD_SAVE_ALL || chs == 1'(c)) begin
               nv_r[c] <= wip_r[c]; // [R3]
            end
         end
      end
   end

   // Ready-low window of the timed commands
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy_r <= '0;
      end else if (save_go) begin
         busy_r <= BUSY_W'(SAVE_CYC); // [R9] [R10]
      end else if (accept && cmd == CMD_PRESET) begin
         busy_r <= BUSY_W'(PRESET_CYC); // [R10]
      end else if (preset_go || restore_go) begin
         busy_r <= BUSY_W'(RESTORE_CYC); // [R4] [R10]
      end else if (busy) begin
         busy_r <= busy_r - BUSY_W'(1);
      end
   end

   assign o_ready     = ~busy;
   assign bus.tx_byte = tol_sel_r ? TOLERANCE_VAL : wip_r[ins_ch_r]; // [R12] [R13]
   assign o_wiper0    = wip_r[0];
   assign o_wiper1    = wip_r[1];

   // Sticky event status; a set in the clearing cycle wins
   assign clr = (i_reg_we && i_reg_addr == REG_IRQ_CLR) ? i_reg_wdata[EV_W-1:0] : '0;
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~clr) | {lock_ev, wp_ev, done_ev};
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         en_r <= IRQ_EN_RST;
      end else if (i_reg_we && i_reg_addr == REG_IRQ_EN) begin
         en_r <= i_reg_wdata[EV_W-1:0];
      end
   end

   assign o_irq = |(stat_r & en_r);

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_r <= 32'h0;
      end else if (i_reg_re) begin
         case (i_reg_addr)
            REG_STATUS: rdata_r <= {29'h0, stat_r};
            REG_IRQ_EN: rdata_r <= {29'h0, en_r};
            REG_WIPER0: rdata_r <= {24'h0, wip_r[0]};
            REG_WIPER1: rdata_r <= {24'h0, wip_r[1]};
            REG_STATE:  rdata_r <= {30'h0, filt_r[2], ~busy};
            default:    rdata_r <= 32'h0;
         endcase
      end else begin
         rdata_r <= 32'h0;
      end
   end

   assign o_reg_rdata = rdata_r;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   property p_direct;
      wr_go && !ins_ch_r && !preset_go |=> wip_r[0] == ($past(bus.rx_byte) & FULL_SCALE);
   endproperty
   a_direct: assert property (p_direct) else $error("direct write not loaded"); // [R1]

   property p_restore;
      restore_go && !chs |=> wip_r[0] == $past(nv_r[0]);
   endproperty
   a_restore: assert property (p_restore) else $error("restore did not copy store"); // [R2]

   property p_save;
      save_go && !chs |=> nv_r[0] == $past(wip_r[0]) ##1 !o_ready;
   endproperty
   a_save: assert property (p_save) else $error("save did not copy wiper"); // [R3]

   property p_pwrup;
      pwrup_r |=> wip_r[1] == $past(nv_r[1]) && !o_ready;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("power-up preset missing"); // [R4]

   property p_ext;
      ext_preset |=> wip_r[0] == $past(nv_r[0]) && wip_r[1] == $past(nv_r[1]);
   endproperty
   a_ext: assert property (p_ext) else $error("external preset missing"); // [R5]

   property p_inc;
      accept && cmd == CMD_INC && chs && !preset_go |=>
         wip_r[1] == (($past(wip_r[1]) >= FULL_SCALE) ? FULL_SCALE : $past(wip_r[1]) + 8'h01);
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong"); // [R6]

   property p_shr;
      accept && cmd == CMD_SHR && chs && !preset_go |=> wip_r[1] == ($past(wip_r[1]) >> 1);
   endproperty
   a_shr: assert property (p_shr) else $error("shift right wrong"); // [R7]

   property p_store_busy;
      save_go |=> !o_ready [*8];
   endproperty
   a_store_busy: assert property (p_store_busy) else $error("ready rose during store"); // [R10]

   property p_wp;
      wp_ev |=> $stable(nv_r[0]) && $stable(nv_r[1]) && o_ready;
   endproperty
   a_wp: assert property (p_wp) else $error("store changed while protected"); // [R15]

   property p_lock;
      busy && !ext_preset |=> $stable(wip_r[0]) && $stable(wip_r[1]);
   endproperty
   a_lock: assert property (p_lock) else $error("wiper changed during update"); // [R16]

   c_save:    cover property (save_go);
   c_restore: cover property (restore_go);
   c_direct:  cover property (wr_go);
   c_wp:      cover property (wp_ev);
endmodule : dual_wiper_nv_control

/* File: logic/dual_wiper_pkg.sv */
// Package: constants, command codes and state types of the dual wiper controller
// Assumes a 100 MHz system clock and the 256-step variant unless STEP_256 is cleared
package dual_wiper_pkg;
   localparam int          CLK_MHZ       = 100;
   localparam bit          STEP_256      = 1'b1;
   localparam logic [7:0]  FULL_SCALE    = STEP_256 ? 8'hFF : 8'h3F;
   localparam logic [7:0]  MID_SCALE     = STEP_256 ? 8'h80 : 8'h20;
   localparam logic [4:0]  ADDR_FIXED    = 5'h0B;
   localparam logic [7:0]  TOLERANCE_VAL = 8'h00;
   // Times of the ready-low windows
   localparam real         T_SAVE_MS     = 20.0;
   localparam real         T_PRESET_MS   = 1.0;
   localparam real         T_RESTORE_MS  = 0.1;
   localparam int          SAVE_CYC_DEF    = int'(T_SAVE_MS * 1000.0 * CLK_MHZ);
   localparam int          PRESET_CYC_DEF  = int'(T_PRESET_MS * 1000.0 * CLK_MHZ);
   localparam int          RESTORE_CYC_DEF = int'(T_RESTORE_MS * 1000.0 * CLK_MHZ);
   localparam int          BUSY_W        = 22;
   // Register port map
   localparam logic [7:0]  REG_STATUS    = 8'h00;
   localparam logic [7:0]  REG_IRQ_CLR   = 8'h04;
   localparam logic [7:0]  REG_IRQ_EN    = 8'h08;
   localparam logic [7:0]  REG_WIPER0    = 8'h0C;
   localparam logic [7:0]  REG_WIPER1    = 8'h10;
   localparam logic [7:0]  REG_STATE     = 8'h14;
   localparam int          EV_W          = 3;
   localparam logic [2:0]  IRQ_EN_RST    = 3'h0;
   // Synchroniser reset: {sel_hi, sel_lo, preset_n, wp_n, sda, scl}
   localparam logic [5:0]  SYNC_RST      = 6'h0F;

   typedef enum logic [3:0] {
      CMD_DIRECT      = 4'h0,
      CMD_TOL         = 4'h1,
      CMD_SAVE_CH     = 4'h2,
      CMD_SAVE_ALL    = 4'h3,
      CMD_INC         = 4'h4,
      CMD_DEC         = 4'h5,
      CMD_SHL         = 4'h6,
      CMD_SHR         = 4'h7,
      CMD_PRESET      = 4'h8,
      CMD_RESTORE_CH  = 4'h9,
      CMD_RESTORE_ALL = 4'hA,
      CMD_NONE        = 4'hF
   } cmd_t;

   typedef enum logic [4:0] {
      SB_IDLE = 5'b00001,
      SB_RX   = 5'b00010,
      SB_RACK = 5'b00100,
      SB_TX   = 5'b01000,
      SB_TACK = 5'b10000
   } sb_state_t;
endpackage : dual_wiper_pkg

/* File: logic/serial_cmd_if.sv */
// Interface: byte-level link between the serial engine and the command core
// Assumes both ends run on the system clock
`timescale 1ns/1ps
interface serial_cmd_if;
   logic       scl;
   logic       sda;
   logic       sda_oe;
   logic       rnw;
   logic       rx_stb;
   logic [1:0] rx_idx;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic [6:0] dev_addr;
   modport engine (input scl, sda, dev_addr, tx_byte, output sda_oe, rnw, rx_stb, rx_idx, rx_byte);
   modport core   (output scl, sda, dev_addr, tx_byte, input sda_oe, rnw, rx_stb, rx_idx, rx_byte);
endinterface : serial_cmd_if

/* File: logic/serial_byte_engine.sv */
// Two-wire serial slave: start/stop detection, address match, acknowledge, byte shift
// Assumes scl and sda are already synchronised to the system clock
`timescale 1ns/1ps
module serial_byte_engine (
   input wire logic      i_sys_clk,
   input wire logic      i_sys_rst,
   serial_cmd_if.engine  bus
);
   import dual_wiper_pkg::*;

   sb_state_t  st_r;
   logic       scl_d_r;
   logic       sda_d_r;
   logic       nack_r;
   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   logic [1:0] idx_r;
   logic       start;
   logic       stp;
   logic       rise;
   logic       fall;

   assign start = bus.scl & scl_d_r & sda_d_r & ~bus.sda;
   assign stp   = bus.scl & scl_d_r & ~sda_d_r & bus.sda;
   assign rise  = bus.scl & ~scl_d_r;
   assign fall  = ~bus.scl & scl_d_r;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= bus.scl;
         sda_d_r <= bus.sda;
      end
   end

   // Frame: address byte, ack, instruction byte, ack, data bytes with ack, stop [R11]
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_r        <= SB_IDLE;
         sh_r        <= 8'h00;
         cnt_r       <= 4'h0;
         idx_r       <= 2'h0;
         nack_r      <= 1'b0;
         bus.sda_oe  <= 1'b0;
         bus.rnw     <= 1'b0;
         bus.rx_stb  <= 1'b0;
         bus.rx_idx  <= 2'h0;
         bus.rx_byte <= 8'h00;
      end else begin
         bus.rx_stb <= 1'b0;
         if (start) begin
            st_r       <= SB_RX;
            cnt_r      <= 4'h0;
            idx_r      <= 2'h0;
            bus.sda_oe <= 1'b0;
         end else if (stp) begin
            st_r       <= SB_IDLE;
            bus.sda_oe <= 1'b0;
         end else begin
            case (st_r)
               SB_RX: begin
                  if (rise) begin
                     sh_r  <= {sh_r[6:0], bus.sda};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (fall && cnt_r == 4'h8) begin
                     if (idx_r == 2'h0 && sh_r[7:1] != bus.dev_addr) begin // [R17]
                        st_r <= SB_IDLE;
                     end else begin
                        bus.sda_oe <= 1'b1;
                        st_r       <= SB_RACK;
                        if (idx_r == 2'h0) begin
                           bus.rnw <= sh_r[0];
                        end else begin
                           bus.rx_stb  <= 1'b1;
                           bus.rx_byte <= sh_r;
                        end
                        bus.rx_idx <= idx_r;
                        if (idx_r != 2'h2) begin
                           idx_r <= idx_r + 2'h1;
                        end
                     end
                  end
               end
               SB_RACK: begin
                  if (fall) begin
                     cnt_r <= 4'h0;
                     if (bus.rnw) begin
                        st_r       <= SB_TX;
                        sh_r       <= bus.tx_byte;
                        bus.sda_oe <= ~bus.tx_byte[7];
                     end else begin
                        st_r       <= SB_RX;
                        bus.sda_oe <= 1'b0;
                     end
                  end
               end
               SB_TX: begin
                  if (fall) begin
                     if (cnt_r == 4'h7) begin
                        st_r       <= SB_TACK;
                        bus.sda_oe <= 1'b0;
                     end else begin
                        sh_r       <= {sh_r[6:0], 1'b0};
                        bus.sda_oe <= ~sh_r[6];
                        cnt_r      <= cnt_r + 4'h1;
                     end
                  end
               end
               SB_TACK: begin
                  if (rise) begin
                     nack_r <= bus.sda;
                  end else if (fall) begin
                     if (nack_r) begin
                        st_r <= SB_IDLE;
                     end else begin
                        st_r       <= SB_TX;
                        sh_r       <= bus.tx_byte;
                        bus.sda_oe <= ~bus.tx_byte[7];
                        cnt_r      <= 4'h0;
                     end
                  end
               end
               default: begin
                  st_r <= SB_IDLE;
               end
            endcase
         end
      end
   end
endmodule : serial_byte_engine

/* File: testbench/serial_master_model.sv */
// Behavioural two-wire bus master: drives the clock and the open-drain data line
// Assumes the bench resolves the data wire from both parties with a pull-up
`timescale 1ns/1ps
module serial_master_model #(
   parameter int Q = 200
) (
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Start: data falls while clock is high
   task automatic start();
      // Small offset keeps every pin edge clear of the system clock edges
      #(Q + 3) o_sda = 1'b0;
      #(Q) o_scl = 1'b0;
   endtask : start
   // Stop: data rises while clock is high, then both lines rest high
   task automatic stop();
      o_sda = 1'b0;
      #(Q) o_scl = 1'b1;
      #(Q) o_sda = 1'b1;
      #(Q);
   endtask : stop
   // One bit: data moves only while clock is low, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      o_sda = b;
      #(Q) o_scl = 1'b1;
      #(2*Q) r = i_sda;
      o_scl = 1'b0;
      #(Q);
   endtask : bit_io
   // Byte MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] b, input logic a_in, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(a_in, a);
   endtask : xfer
endmodule : serial_master_model

/* File: testbench/tb_dual_wiper_nv_control.sv */
// Self-checking bench: serial frames, register port, preset and protect pins
// Assumes the design package and the serial master model are compiled first
`timescale 1ns/1ps
module tb_dual_wiper_nv_control;
   import dual_wiper_pkg::*;
   localparam int SV_N = 3000, PR_N = 500, RS_N = 200;
   logic        clk = 0, rst = 1, wp_n = 1, pre_n = 1, we = 0, re = 0, re_d = 0;
   logic        sel_lo, sel_hi, scl, sda_m, sda_oe, sda_out, rdy, irq, ak;
   logic [7:0]  w0, w1, addr = 0, rb, v0, v1;
   logic [31:0] wd = 0, rd, exp_v;
   logic [31:0] exp_q[$];
   logic [15:0] seq[12] = '{16'h01FF, 16'h4100, 16'h7100, 16'h6100, 16'h6100, 16'h5100,
                           16'h0100, 16'h5100, 16'h4100, 16'h6100, 16'h7100, 16'h7100};
   int          failures = 0, checks_done = 0, cyc = 0, lo_n = 0, last_lo = 0;
   wire         sda = sda_oe ? (sda_out & sda_m) : sda_m;

   dual_wiper_nv_control #(.SAVE_CYC(SV_N), .PRESET_CYC(PR_N), .RESTORE_CYC(RS_N)) dut (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_wp_n(wp_n), .i_preset_n(pre_n), .i_address_select_bit_lo(sel_lo), .i_address_select_bit_hi(sel_hi),
      .o_ready(rdy), .o_wiper0(w0), .o_wiper1(w1), .o_irq(irq), .i_reg_addr(addr), .i_reg_wdata(wd),
      .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rd));
   serial_master_model m (.i_sda(sda), .o_scl(scl), .o_sda(sda_m));

   always #5 clk = ~clk;

   // Read-data watcher, ready-low run length and hang guard
   always @(posedge clk) begin
      re_d <= re;
      if (re_d) chk(rd, exp_q.pop_front());
      if (!rdy) lo_n <= lo_n + 1;
      else if (lo_n != 0) begin
         last_lo <= lo_n;
         lo_n <= 0;
      end
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         failures++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      re <= 1'b0;
   endtask : reg_rd

   task automatic wait_rdy();
      for (int i = 0; i < 6000 && rdy !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
   endtask : wait_rdy

   // Write frame; data byte only for a direct write; a bad address expects no acknowledge
   task automatic sw(input logic [7:0] ins, input logic [7:0] dat, input logic good = 1'b1);
      m.start();
      m.xfer({ADDR_FIXED ^ {4'h0, !good}, sel_hi, sel_lo, 1'b0}, 1'b1, rb, ak);
      chk(ak, !good);
      m.xfer(ins, 1'b1, rb, ak);
      chk(ak, !good);
      if (ins[7:4] == 4'h0) begin
         m.xfer(dat, 1'b1, rb, ak);
         chk(ak, !good);
      end
      m.stop();
      repeat (30) @(posedge clk);
   endtask : sw

   task automatic sr(input logic [7:0] e);
      m.start();
      m.xfer({ADDR_FIXED, sel_hi, sel_lo, 1'b1}, 1'b1, rb, ak);
      m.xfer(8'hFF, 1'b1, rb, ak);
      chk(rb, e);
      m.stop();
   endtask : sr

   function automatic logic [7:0] step(input logic [7:0] ins, input logic [7:0] v, input logic [7:0] d);
      case (ins[7:4])
         4'h0: return d & FULL_SCALE;
         4'h4: return (v == FULL_SCALE) ? v : v + 8'h01;
         4'h5: return (v == 8'h00) ? v : v - 8'h01;
         4'h6: return (v > (FULL_SCALE >> 1)) ? FULL_SCALE : v << 1;
         default: return v >> 1;
      endcase
   endfunction : step

   initial begin
      void'($urandom(84));
      {sel_hi, sel_lo} = 2'($urandom);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk(rdy, 0);
      wait_rdy();
      chk(last_lo, RS_N);
      chk({w1, w0}, {MID_SCALE, MID_SCALE});
      reg_rd(REG_IRQ_EN, 0);
      reg_rd(8'h20, 0);
      v0 = 8'($urandom) & FULL_SCALE;
      v1 = ~v0 & FULL_SCALE;
      sw(8'h00, v0);
      sw(8'h01, v1);
      chk({w1, w0}, {v1, v0});
      reg_rd(REG_WIPER0, v0);
      reg_rd(REG_WIPER1, v1);
      sr(v1);
      // Saturating step, shift and direct loads on channel 1
      foreach (seq[k]) begin
         sw(seq[k][15:8], seq[k][7:0]);
         exp_v = step(seq[k][15:8], exp_v[7:0], seq[k][7:0]);
         chk(w1, exp_v);
      end
      // Save, then a write during the busy window is ignored
      reg_wr(REG_IRQ_CLR, 7);
      sw(8'h20, 0);
      chk(rdy, 0);
      sw(8'h00, ~v0);
      wait_rdy();
      chk(last_lo, SV_N);
      chk(w0, v0);
      reg_rd(REG_STATUS, 5);
      reg_wr(REG_IRQ_EN, 4);
      #1 chk(irq, 1);
      reg_wr(REG_IRQ_CLR, 4);
      #1 chk(irq, 0);
      reg_rd(REG_STATUS, 1);
      sw(8'h00, ~v0);
      sw(8'h90, 0);
      wait_rdy();
      chk({w0, last_lo[15:0]}, {v0, 16'(RS_N)});
      // Protected save is refused and leaves the store alone
      wp_n <= 1'b0;
      sw(8'h00, ~v0);
      sw(8'h20, 0);
      chk(rdy, 1);
      reg_rd(REG_STATE, 1);
      sw(8'h90, 0);
      wait_rdy();
      chk(w0, v0);
      wp_n <= 1'b1;
      sw(8'h30, 0);
      wait_rdy();
      chk(last_lo, SV_N);
      sw(8'h01, v1);
      sw(8'hA0, 0);
      wait_rdy();
      chk({w1, w0}, {8'h00, v0});
      sw(8'h01, v1);
      pre_n <= 1'b0;
      repeat (10) @(posedge clk);
      pre_n <= 1'b1;
      wait_rdy();
      chk({w1, w0, last_lo[15:0]}, {8'h00, v0, 16'(RS_N)});
      sw(8'h01, v1);
      sw(8'h80, 0);
      wait_rdy();
      chk({w1, w0, last_lo[15:0]}, {8'h00, v0, 16'(PR_N)});
      sw(8'h10, 0);
      sr(TOLERANCE_VAL);
      sw(8'h00, 8'h3C, 1'b0);
      chk(w0, v0);
      results();
   end
endmodule : tb_dual_wiper_nv_control
